// *** hdl/rcc_defines.svh ***
// Register offsets, field positions and timing counts of the reset cause controller.
`ifndef RCC_DEFINES_SVH
`define RCC_DEFINES_SVH
`define RCC_OFS_CAUSE 16'hf058
`define RCC_OFS_SAFETY 16'hf05a
`define RCC_OFS_CTRL 16'hf060
`define RCC_OFS_STATE 16'hf064
`define RCC_BIT_POR 0
`define RCC_BIT_WDOVF 2
`define RCC_BIT_WDWIN 3
`define RCC_BIT_SUPPLY 4
`define RCC_BIT_PIN 6
`define RCC_BIT_STARTERR 7
`define RCC_BIT_BREAK 8
`define RCC_BIT_ROMACC 0
`define RCC_BIT_PARITY 1
`define RCC_CAUSE_MASK 16'h01dd
`define RCC_SAFETY_MASK 8'h03
`define RCC_CTRL_RESET 32'h0000_0003
`define RCC_VEC_SP 16'h0000
`define RCC_VEC_PC 16'h0002
`define RCC_VEC_BRK 16'h0004
`define RCC_PHASE_CYCLES 4
`endif

// *** hdl/rcc_pkg.sv ***
// Types shared by the reset cause controller.
package rcc_pkg;
	typedef enum logic [2:0] {
		RCC_RUN, RCC_HW, RCC_SFR, RCC_CPU_SP, RCC_CPU_PC, RCC_HOLD
	} rcc_phase_e;
	typedef struct packed {
		logic pin;
		logic por;
		logic supply;
		logic wd_overflow;
		logic wd_window;
		logic parity;
		logic rom_access;
		logic brk;
		logic init_fail;
	} rcc_src_s;
	typedef struct packed {
		logic cpu;
		logic sfr;
		logic periph;
		logic core_hw;
		logic supervisor;
		logic [31:0] block;
	} rcc_rst_s;
	typedef struct packed {
		logic req;
		logic [15:0] addr;
	} rcc_fetch_s;
endpackage : rcc_pkg

// *** hdl/rcc_sync.sv ***
// Two-flop synchroniser for the reset pin.
`timescale 1ns/1ns
`default_nettype none
module rcc_sync (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Level in and out
	input wire logic d,
	output logic q
);
	logic meta_q;
	logic sync_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end
	assign q = sync_q;
endmodule : rcc_sync
`default_nettype wire

// *** hdl/rcc_top.sv ***
// Reset cause controller: system reset sequencing, cause flags and AXI4-Lite registers.
// Operation
// [RULE_01] A reset sets only its own cause flag; others keep value, start-up error excepted.
// [RULE_02] Writing all ones to the cause register clears it to zero; the code leaves bit 7 set.
// [RULE_03] Bit 0 records power-on reset, cleared by writing one.
// [RULE_04] Bits 2 and 3 record watchdog overflow and window resets, write one clears.
// [RULE_05] Bits 4 and 6 record supervisor and pin resets, write one clears.
// [RULE_06] Bit 7 flags failed start-up; only pin or power-on reset clears it.
// [RULE_07] Bit 8 records break instruction reset, cleared by writing one.
// [RULE_08] Safety register sets only its cause; writing all ones clears it.
// [RULE_09] Safety bit 0 is ROM unused access, bit 1 RAM parity.
// [RULE_10] ROM access and parity resets are enabled independently.
// [RULE_11] System causes reset CPU, SFRs, peripherals, core; pin and power-on reset supervisor.
// [RULE_12] Break causes CPU reset only at exception level two or more.
// [RULE_13] Break reset touches only the CPU.
// [RULE_14] Block resets hit selected peripherals only, no system reset mode.
// [RULE_15] All other causes enter system reset mode, with top priority.
// [RULE_16] Sequence: core hardware, then SFRs, then CPU registers.
// [RULE_17] Stack pointer from vector 0x0000, program counter from 0x0002.
// [RULE_18] Break reset takes PC from 0x0004 at level 0 or 1, else 0x0002; the code starts break resets only at level 2 or more, so always 0x0002.
// [RULE_19] Low reset pin holds reset and sets pin flag; high releases it.
// [RULE_20] The outside driver holds the pin low for the hold time.
// [RULE_21] After power-on the CPU starts on the low-speed clock.
// [RULE_22] Software switches to high-speed clock only after supply is confirmed; the code has no write path to low_speed_clock, so it stays set.
// [RULE_23] The reset pin is synchronised before internal reset is released.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rcc_defines.svh"
module rcc_top import rcc_pkg::*; #(
	parameter int PHASE_CYCLES = `RCC_PHASE_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Reset sources
	input wire logic reset_pin_n,
	input wire rcc_src_s src,
	input wire logic [1:0] exception_level,
	input wire logic [31:0] block_reset_controls,
	// Vector fetch
	output rcc_fetch_s fetch,
	input wire logic fetch_ack,
	input wire logic [15:0] fetch_data,
	// Reset outputs and CPU start values
	output rcc_rst_s rst,
	output logic [15:0] cpu_sp,
	output logic [15:0] cpu_pc,
	output logic low_speed_clock_sel,
	output logic system_reset_active,
	// AXI4-Lite write
	input wire logic [15:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// AXI4-Lite read
	input wire logic [15:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	typedef struct packed {
		rcc_phase_e phase;
		logic [7:0] cnt;
		logic brk_seq;
		logic brk_low;
		logic [15:0] cause;
		logic [7:0] safety;
		logic [1:0] enables;
		logic aw_got;
		logic w_got;
		logic [15:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic fetch_req;
		logic [15:0] fetch_addr;
		logic [15:0] sp;
		logic [15:0] pc;
		logic low_speed_clock;
		logic sup_rst;
		logic [31:0] block;
	} rcc_state_s;

	rcc_state_s q;
	rcc_state_s d;
	logic pin_low;
	logic pin_sync;
	logic sys_evt;
	logic brk_evt;
	logic wr_fire;
	logic [31:0] wmask;
	logic [15:0] cause_set;
	logic [7:0] safety_set;
	logic [31:0] rd_val;
	logic rd_ok;

	// ------------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------------
	rcc_sync u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(~reset_pin_n),
		.q(pin_sync)
	); // see [RULE_23]
	assign pin_low = pin_sync;

	// ------------------------------------------------------------------
	// Reset event decode
	// ------------------------------------------------------------------
	always_comb begin
		cause_set = 16'h0000;
		safety_set = 8'h00;
		cause_set[`RCC_BIT_POR] = src.por; // see [RULE_03]
		cause_set[`RCC_BIT_WDOVF] = src.wd_overflow; // see [RULE_04]
		cause_set[`RCC_BIT_WDWIN] = src.wd_window; // see [RULE_04]
		cause_set[`RCC_BIT_SUPPLY] = src.supply; // see [RULE_05]
		cause_set[`RCC_BIT_PIN] = pin_low; // see [RULE_19]
		cause_set[`RCC_BIT_BREAK] = brk_evt; // see [RULE_07]
		safety_set[`RCC_BIT_ROMACC] = src.rom_access & q.enables[0]; // see [RULE_09] [RULE_10]
		safety_set[`RCC_BIT_PARITY] = src.parity & q.enables[1]; // see [RULE_09] [RULE_10]
	end
	assign sys_evt = (|cause_set[6:0]) | (|safety_set); // see [RULE_15]
	assign brk_evt = src.brk && (exception_level >= 2'd2) && (q.phase == RCC_RUN); // see [RULE_12]

	assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{q.w_strb[i]}};
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		unique case (s_araddr & 16'hfffc)
			// The safety byte shares the cause word, in lane 2.
			`RCC_OFS_CAUSE: rd_val = {8'h00, q.safety, q.cause};
			`RCC_OFS_CTRL: rd_val = {30'h0000_0000, q.enables};
			`RCC_OFS_STATE: rd_val = {28'h000_0000, q.low_speed_clock, q.phase};
			default: begin
				rd_val = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		// Bus write path; clears apply first so a same-cycle event set wins below.
		if (s_awvalid && !q.aw_got) begin
			d.aw_got = 1'b1;
			d.aw_addr = s_awaddr;
		end
		if (s_wvalid && !q.w_got) begin
			d.w_got = 1'b1;
			d.w_data = s_wdata;
			d.w_strb = s_wstrb;
		end
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = 2'b00;
			unique case (q.aw_addr & 16'hfffc)
				`RCC_OFS_CAUSE: begin
					d.cause = q.cause & ~(q.w_data[15:0] & wmask[15:0] & `RCC_CAUSE_MASK
						& ~(16'h0001 << `RCC_BIT_STARTERR)); // see [RULE_02] [RULE_06]
					d.safety = q.safety & ~(q.w_data[23:16] & wmask[23:16] & `RCC_SAFETY_MASK); // see [RULE_08]
				end
				`RCC_OFS_CTRL:
					if (q.w_strb[0]) begin
						d.enables = q.w_data[1:0]; // see [RULE_10]
					end
				default: d.bresp = 2'b10;
			endcase
		end
		if (q.bvalid && s_bready) begin
			d.bvalid = 1'b0;
		end
		if (s_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rdata = rd_val;
			d.rresp = rd_ok ? 2'b00 : 2'b10;
		end else if (q.rvalid && s_rready) begin
			d.rvalid = 1'b0;
		end
		// Event sets win over software clears.
		d.cause = d.cause | cause_set; // see [RULE_01]
		d.safety = d.safety | safety_set; // see [RULE_08]
		if (pin_low || src.por) begin
			d.cause[`RCC_BIT_STARTERR] = 1'b0; // see [RULE_06]
		end
		if (src.por) begin
			d.low_speed_clock = 1'b1; // see [RULE_21]
		end
		d.block = block_reset_controls; // see [RULE_14]
		d.fetch_req = 1'b0;
		d.cnt = q.cnt + 8'd1;

		// Reset sequence: a system cause restarts it from any phase.
		if (sys_evt) begin
			d.phase = (pin_low || src.por || src.supply) ? RCC_HOLD : RCC_HW; // see [RULE_15] [RULE_19]
			d.cnt = 8'd0;
			d.brk_seq = 1'b0;
			d.sup_rst = pin_low || src.por; // see [RULE_11]
		end else begin
			unique case (q.phase)
				RCC_RUN: begin
					if (brk_evt) begin
						d.phase = RCC_CPU_SP; // see [RULE_13]
						d.brk_seq = 1'b1;
						d.brk_low = exception_level < 2'd2;
						d.cnt = 8'd0;
					end
				end
				RCC_HOLD: begin
					d.phase = RCC_HW;
					d.cnt = 8'd0;
				end
				RCC_HW: begin
					if (src.init_fail) begin
						d.cause[`RCC_BIT_STARTERR] = 1'b1; // see [RULE_06]
					end
					if (q.cnt == 8'(PHASE_CYCLES - 1)) begin
						d.phase = RCC_SFR; // see [RULE_16]
						d.cnt = 8'd0;
					end
				end
				RCC_SFR: begin
					if (q.cnt == 8'(PHASE_CYCLES - 1)) begin
						d.phase = RCC_CPU_SP; // see [RULE_16]
						d.cnt = 8'd0;
					end
				end
				RCC_CPU_SP: begin
					d.fetch_req = 1'b1;
					d.fetch_addr = `RCC_VEC_SP; // see [RULE_17]
					if (q.fetch_req && fetch_ack) begin
						d.sp = fetch_data;
						d.fetch_req = 1'b0;
						d.phase = RCC_CPU_PC;
					end
				end
				RCC_CPU_PC: begin
					d.fetch_req = 1'b1;
					d.fetch_addr = (q.brk_seq && q.brk_low) ? `RCC_VEC_BRK : `RCC_VEC_PC; // see [RULE_17] [RULE_18]
					if (q.fetch_req && fetch_ack && q.fetch_addr == d.fetch_addr) begin
						d.pc = fetch_data;
						d.fetch_req = 1'b0;
						d.phase = RCC_RUN;
						d.brk_seq = 1'b0;
					end
				end
			endcase
		end
		// The pin keeps the device parked until it goes high again.
		if (pin_low) begin
			d.phase = RCC_HOLD; // see [RULE_19]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.phase <= RCC_HOLD;
			q.cause <= 16'h0001;
			q.enables <= 2'(`RCC_CTRL_RESET);
			q.low_speed_clock <= 1'b1;
			q.sup_rst <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	logic sys_phase;
	assign sys_phase = (q.phase != RCC_RUN) && !q.brk_seq;
	assign system_reset_active = sys_phase;
	always_comb begin
		rst.cpu = q.phase != RCC_RUN; // see [RULE_11] [RULE_13]
		rst.sfr = sys_phase && (q.phase == RCC_HOLD || q.phase == RCC_HW || q.phase == RCC_SFR);
		rst.periph = rst.sfr; // see [RULE_11]
		rst.core_hw = sys_phase && (q.phase == RCC_HOLD || q.phase == RCC_HW); // see [RULE_16]
		// The sticky flag would also hold the supervisor in later resets, so the cause is kept.
		rst.supervisor = (q.phase == RCC_HOLD) && (pin_low || q.sup_rst); // see [RULE_11]
		rst.block = q.block; // see [RULE_14]
	end
	assign fetch.req = q.fetch_req;
	assign fetch.addr = q.fetch_addr;
	assign cpu_sp = q.sp;
	assign cpu_pc = q.pc;
	assign low_speed_clock_sel = q.low_speed_clock;
	assign s_awready = !q.aw_got;
	assign s_wready = !q.w_got;
	assign s_bvalid = q.bvalid;
	assign s_bresp = q.bresp;
	assign s_arready = !q.rvalid;
	assign s_rvalid = q.rvalid;
	assign s_rdata = q.rdata;
	assign s_rresp = q.rresp;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence seq_sys_cause;
		sys_evt;
	endsequence
	sequence seq_cpu_init;
		q.phase == RCC_CPU_SP ##[1:300] q.phase == RCC_CPU_PC;
	endsequence
	chk_pin_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		pin_low |=> q.cause[`RCC_BIT_PIN] && q.phase == RCC_HOLD) else $error("pin flag"); // see [RULE_19]
	chk_por_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		src.por |=> q.cause[`RCC_BIT_POR] && !q.cause[`RCC_BIT_STARTERR]) else $error("por flag"); // see [RULE_03]
	chk_others_kept: assert property (@(posedge aclk) disable iff (!aresetn)
		(!wr_fire && !src.por && !pin_low) |=> (q.cause & ~16'h0080) >= ($past(q.cause) & ~16'h0080)
		&& ((q.cause & $past(q.cause)) == $past(q.cause))) else $error("flag lost"); // see [RULE_01]
	chk_sys_enters: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_sys_cause |=> system_reset_active && rst.cpu) else $error("no reset"); // see [RULE_15]
	chk_brk_level: assert property (@(posedge aclk) disable iff (!aresetn)
		(src.brk && exception_level < 2'd2 && !sys_evt && q.phase == RCC_RUN)
		|=> q.phase == RCC_RUN) else $error("brk low level"); // see [RULE_12]
	chk_brk_cpu_only: assert property (@(posedge aclk) disable iff (!aresetn)
		q.brk_seq |-> !rst.periph && !rst.sfr && !rst.core_hw) else $error("brk wide"); // see [RULE_13]
	chk_parity_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(!q.enables[1] && !q.safety[1]) |=> !q.safety[1]) else $error("parity gated"); // see [RULE_10]
	chk_init_order: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.phase == RCC_SFR && !sys_evt && !pin_low) |-> !rst.core_hw && rst.sfr) else $error("order"); // see [RULE_16]
	chk_sp_vector: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.phase == RCC_CPU_SP && q.fetch_req) |-> fetch.addr == `RCC_VEC_SP) else $error("sp vec"); // see [RULE_17]
	chk_pc_vector: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.phase == RCC_CPU_PC && q.fetch_req && q.brk_seq && q.brk_low)
		|-> fetch.addr == `RCC_VEC_BRK) else $error("pc vec"); // see [RULE_18]
	chk_block_only: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.phase == RCC_RUN && |q.block && !sys_evt) |-> !system_reset_active) else $error("block"); // see [RULE_14]
	chk_cpu_init_seq: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_cpu_init) |=> fetch.addr inside {`RCC_VEC_PC, `RCC_VEC_BRK}) else $error("cpu init"); // see [RULE_16]
endmodule : rcc_top
`default_nettype wire

// *** tb/rcc_vec_mem.sv ***
// Program memory model that answers the vector fetches of the reset cause controller.
`timescale 1ns/1ns
`default_nettype none
module rcc_vec_mem import rcc_pkg::*; #(
	parameter logic [15:0] SP_V = 16'h1ff0,
	parameter logic [15:0] PC_V = 16'h0200,
	parameter logic [15:0] BRK_V = 16'h0300
) (
	// Clock
	input wire logic aclk,
	// Fetch port
	input wire rcc_fetch_s fetch,
	input wire logic slow,
	output logic fetch_ack,
	output logic [15:0] fetch_data
);
	logic [3:0] cnt_q = 4'h0;
	logic [15:0] addr_q = 16'h0000;
	logic [15:0] pat_q = 16'h5a5a;
	logic [15:0] word;
	always_ff @(posedge aclk) begin
		addr_q <= fetch.addr;
		pat_q <= ~pat_q;
		if (!fetch.req || fetch.addr != addr_q)
			cnt_q <= 4'h0;
		else if (cnt_q != 4'hf)
			cnt_q <= cnt_q + 4'h1;
	end
	always_comb begin
		case (fetch.addr)
			16'h0000: word = SP_V;
			16'h0002: word = PC_V;
			16'h0004: word = BRK_V;
			default: word = pat_q;
		endcase
	end
	// A slow answer comes five cycles late; off the answer the data lines wander every cycle.
	assign fetch_ack = fetch.req && fetch.addr == addr_q && cnt_q >= (slow ? 4'h5 : 4'h0);
	assign fetch_data = fetch_ack ? word : pat_q;
endmodule : rcc_vec_mem
`default_nettype wire

// *** tb/rcc_top_tb.sv ***
// Self-checking bench for the reset cause controller.
`timescale 1ns/1ns
`default_nettype none
`include "rcc_defines.svh"
module rcc_top_tb import rcc_pkg::*; ;
	localparam logic [15:0] SP_V = 16'h1ff0;
	localparam logic [15:0] PC_V = 16'h0200;
	localparam logic [3:0][8:0] SRCS = {9'h010, 9'h020, 9'h040, 9'h080};
	localparam logic [3:0][15:0] BITS = {16'h0008, 16'h0004, 16'h0010, 16'h0001};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic pin_n = 1'b1;
	logic [8:0] sb = 9'h000;
	logic fail_in = 1'b0;
	logic [1:0] lvl = 2'b00;
	logic [31:0] blk = 32'h0000_0000;
	logic slow = 1'b0;
	logic [15:0] awaddr = 16'h0000;
	logic [15:0] araddr = 16'h0000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	wire rcc_src_s src = rcc_src_s'(sb | {8'h00, fail_in});
	rcc_fetch_s fetch;
	rcc_rst_s rst;
	logic ack, low_speed_clock, sra, awready, wready, bvalid, arready, rvalid;
	logic [15:0] fdata, sp, pc, exp_c;
	logic [1:0] bresp, rresp, rd_r;
	logic [31:0] rdata, rd_v;
	logic saw, saw_sup, saw_cpu, saw_per;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	always #20 aclk = ~aclk;
	rcc_top #(.PHASE_CYCLES(4)) dut_u (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(pin_n),
		.src(src), .exception_level(lvl), .block_reset_controls(blk), .fetch(fetch),
		.fetch_ack(ack), .fetch_data(fdata), .rst(rst), .cpu_sp(sp), .cpu_pc(pc),
		.low_speed_clock_sel(low_speed_clock), .system_reset_active(sra), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
		.s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
		.s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
		.s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
	rcc_vec_mem #(.SP_V(SP_V), .PC_V(PC_V), .BRK_V(16'h0300)) vec_u (.aclk(aclk),
		.fetch(fetch), .slow(slow), .fetch_ack(ack), .fetch_data(fdata));
	// ----
	// Tasks
	// ----
	task summarize;
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1 && !awvalid && !wvalid) begin
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr
	task rd(input logic [15:0] a);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1 && !arvalid) begin
				rd_v = rdata;
				rd_r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd
	// Cause flags sit in lanes 1..0 of the word, safety flags in lane 2.
	task rdc(input logic [15:0] e, input logic [7:0] es);
		rd(`RCC_OFS_CAUSE);
		chk(rd_v[15:0], e);
		chk(rd_v[23:16], es);
	endtask : rdc
	task pulse(input logic [8:0] v);
		@(posedge aclk);
		sb <= v;
		@(posedge aclk);
		sb <= 9'h000;
	endtask : pulse
	task watch(input int lim);
		saw = 1'b0;
		saw_sup = 1'b0;
		saw_cpu = 1'b0;
		saw_per = 1'b0;
		for (int n = 0; n < lim; n++) begin
			@(posedge aclk);
			if (sra === 1'b1 || rst.cpu === 1'b1) begin
				saw = 1'b1;
				saw_sup = saw_sup | rst.supervisor;
				saw_cpu = saw_cpu | rst.cpu;
				saw_per = saw_per | rst.periph | rst.sfr | rst.core_hw;
			end else if (saw)
				break;
		end
	endtask : watch
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			summarize();
		end
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		watch(3000);
		chk(sp, SP_V);
		chk(pc, PC_V);
		chk(low_speed_clock, 1'b1);
		rdc(16'h0001, 8'h00);
		rd(`RCC_OFS_CTRL);
		chk(rd_v, `RCC_CTRL_RESET);
		rd(16'h1000);
		chk(rd_r, 2'b10);
		wr(`RCC_OFS_CAUSE, 32'h0000_ffff, 4'h3);
		rdc(16'h0000, 8'h00);
		exp_c = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			pulse(SRCS[i]);
			watch(3000);
			chk(saw_sup, i == 0);
			chk(saw_cpu & saw_per, 1'b1);
			chk(pc, PC_V);
			exp_c = exp_c | BITS[i];
			rdc(exp_c, 8'h00);
		end
		wr(`RCC_OFS_CAUSE, 32'h0000_0004, 4'h3);
		rdc(16'h0019, 8'h00);
		fail_in <= 1'b1;
		pulse(9'h020);
		watch(3000);
		fail_in <= 1'b0;
		rdc(16'h009d, 8'h00);
		wr(`RCC_OFS_CAUSE, 32'h0000_ffff, 4'h3);
		rdc(16'h0080, 8'h00);
		@(posedge aclk);
		pin_n <= 1'b0;
		repeat (20) @(posedge aclk);
		chk(sra, 1'b1);
		chk(rst.supervisor, 1'b1);
		pin_n <= 1'b1;
		watch(3000);
		rdc(16'h0040, 8'h00);
		wr(`RCC_OFS_CAUSE, 32'h00ff_ffff, 4'h7);
		pulse(9'h008);
		watch(3000);
		rdc(16'h0000, 8'h02);
		pulse(9'h004);
		watch(3000);
		rdc(16'h0000, 8'h03);
		wr(`RCC_OFS_CAUSE, 32'h0001_0000, 4'h4);
		rdc(16'h0000, 8'h02);
		wr(`RCC_OFS_CAUSE, 32'h00ff_0000, 4'h4);
		rdc(16'h0000, 8'h00);
		wr(`RCC_OFS_CTRL, 32'h0000_0002, 4'hf);
		pulse(9'h004);
		watch(40);
		chk(saw, 1'b0);
		pulse(9'h008);
		watch(3000);
		chk(saw, 1'b1);
		rdc(16'h0000, 8'h02);
		wr(`RCC_OFS_CTRL, 32'h0000_0003, 4'hf);
		lvl <= 2'd1;
		pulse(9'h002);
		watch(40);
		chk(saw, 1'b0);
		for (int l = 2; l < 4; l++) begin
			lvl <= l[1:0];
			pulse(9'h002);
			watch(3000);
			chk(saw_cpu, 1'b1);
			chk(saw_per | saw_sup, 1'b0);
			chk(pc, PC_V);
			rdc(16'h0100, 8'h02);
			wr(`RCC_OFS_CAUSE, 32'h0000_0100, 4'h3);
		end
		rdc(16'h0000, 8'h02);
		@(posedge aclk);
		blk <= 32'h8000_00a5;
		repeat (3) @(posedge aclk);
		chk(rst.block, 32'h8000_00a5);
		chk({sra, rst.cpu}, 2'b00);
		rdc(16'h0000, 8'h02);
		summarize();
	end
endmodule : rcc_top_tb
`default_nettype wire
